// ### hdl/ecs_pkg.sv
// Package: constants, modes and carriers for eight-channel switch control
package ecs_pkg;
   // ------------------------------------------------------------
   // Sizes
   // ------------------------------------------------------------
   localparam int NUM_CH  = 8;          // Output channels
   localparam int NUM_PIN = 4;          // Direct control pins

   // ------------------------------------------------------------
   // Channel modes (two bits per channel)
   // ------------------------------------------------------------
   typedef enum logic [1:0] {
      ECS_MODE_OFF   = 2'h0,            // Output off
      ECS_MODE_ON    = 2'h1,            // Output on
      ECS_MODE_INPUT = 2'h3,            // Follow selected pin
      ECS_MODE_CLEAR = 2'h2             // clear_standby_mode
   } ecs_mode_e;

   // ------------------------------------------------------------
   // Reset values
   // ------------------------------------------------------------
   localparam logic [1:0] MODE_RST = 2'h0;  // OFF in mode registers
   localparam logic [1:0] SEL_RST  = 2'h0;  // direct_ctrl_pin_1
   localparam logic       OUT_RST  = 1'b0;  // Stages off (cleared)
   localparam logic       STBY_RST = 1'b1;  // Low-power state in reset
   localparam logic       SO_RST   = 1'b1;  // Serial output released

   // ------------------------------------------------------------
   // Write carrier: one channel's programming
   // ------------------------------------------------------------
   typedef struct packed {
      logic [2:0] ch;                   // Target channel
      logic [1:0] mode;                 // ecs_mode_e code
      logic [1:0] pin_sel;              // channel_pin_select
   } ecs_cfg_s;
endpackage

// ### hdl/ecs_switch_ctrl.sv
// Mode control for an eight-channel low-side switch
`timescale 1ns/10ps
module ecs_switch_ctrl
   import ecs_pkg::*;
(
   // Clock and reset
   input  wire logic                clk,
   input  wire logic                rst_n,
   // Programming from serial front end
   input  wire logic                cfg_valid,
   input  wire ecs_cfg_s            cfg,
   // Direct control pins, asynchronous
   input  wire logic [NUM_PIN-1:0]  direct_ctrl_pin,
   // Clamp status per channel, asynchronous
   input  wire logic [NUM_CH-1:0]   clamp_active,
   // Serial chip select, active low, asynchronous
   input  wire logic                spi_cs_n,
   // Outputs
   output logic [NUM_CH-1:0]        out_en,
   output logic                     standby,
   output logic                     so_oe_n
);

   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   logic [1:0]         mode_q [NUM_CH];    // Per-channel mode
   logic [1:0]         sel_q  [NUM_CH];    // Per-channel pin select
   logic [NUM_PIN-1:0] pin_m_q;            // Pin sync stage 1
   logic [NUM_PIN-1:0] pin_s_q;            // Pin sync stage 2
   logic [NUM_CH-1:0]  clp_m_q;            // Clamp sync stage 1
   logic [NUM_CH-1:0]  clp_s_q;            // Clamp sync stage 2
   logic               cs_m_q;             // Chip select stage 1
   logic               cs_s_q;             // Chip select stage 2
   logic [NUM_CH-1:0]  en_d;               // Resolved enables
   logic [NUM_CH-1:0]  clr_v;              // Channel in Clear
   logic [NUM_CH-1:0]  locked_q;           // Waiting for clamp end

   // ------------------------------------------------------------
   // Synchronisers
   // ------------------------------------------------------------
   // Pins cross in through two flops; first stage feeds only second
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         pin_m_q <= '0;
         pin_s_q <= '0;
         clp_m_q <= '0;
         clp_s_q <= '0;
         cs_m_q  <= 1'b1;
         cs_s_q  <= 1'b1;
      end else begin
         pin_m_q <= direct_ctrl_pin;
         pin_s_q <= pin_m_q;
         clp_m_q <= clamp_active;
         clp_s_q <= clp_m_q;
         cs_m_q  <= spi_cs_n;
         cs_s_q  <= cs_m_q;
      end
   end

   // ------------------------------------------------------------
   // Per-channel logic
   // ------------------------------------------------------------
   genvar g;
   generate
      for (g = 0; g < NUM_CH; g++) begin : g_ch
         // Mode and select registers, OFF after reset
         always_ff @(posedge clk) begin
            if (!rst_n) begin
               mode_q[g] <= MODE_RST;
               sel_q[g]  <= SEL_RST;
            end else if (cfg_valid && cfg.ch == 3'(g)) begin
               mode_q[g] <= cfg.mode;
               sel_q[g]  <= cfg.pin_sel;
            end
         end

         // Resolve enable from mode and selected pin
         always_comb begin
            clr_v[g] = (mode_q[g] == ECS_MODE_CLEAR);
            case (ecs_mode_e'(mode_q[g]))
               ECS_MODE_ON:    en_d[g] = 1'b1;
               ECS_MODE_INPUT: en_d[g] = pin_s_q[sel_q[g]];
               default:        en_d[g] = 1'b0;
            endcase
         end

         // Once clamping, hold off until clamp ends and a new off seen
         always_ff @(posedge clk) begin
            if (!rst_n) begin
               locked_q[g] <= 1'b0;
            end else if (clp_s_q[g]) begin
               locked_q[g] <= 1'b1;
            end else if (!en_d[g]) begin
               locked_q[g] <= 1'b0;
            end
         end

         // Registered output stage, cleared in reset
         always_ff @(posedge clk) begin
            if (!rst_n) begin
               out_en[g] <= OUT_RST;
            end else begin
               out_en[g] <= en_d[g] & ~clp_s_q[g]
                            & ~locked_q[g];
            end
         end
      end
   endgenerate

   // ------------------------------------------------------------
   // Standby and serial output enable
   // ------------------------------------------------------------
   // Standby held during reset as well, low-power state
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         standby <= STBY_RST;
      end else begin
         standby <= &clr_v;
      end
   end

   // Active-low enable: high means serial output released
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         so_oe_n <= SO_RST;
      end else begin
         so_oe_n <= cs_s_q;
      end
   end

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   // Reset edge clears every stage and enters low power
   a_off_after_rst: assert property (@(posedge clk)
      !rst_n |=> (out_en == '0) && standby)
      else $error("Outputs not cleared after reset");

   // Channel 5 mode register loads OFF on every reset edge
   a_mode_rst_off: assert property (@(posedge clk)
      !rst_n |=> (mode_q[5] == ECS_MODE_OFF))
      else $error("Mode register not reset to OFF");

   // Serial output released while reset is held
   a_so_reset: assert property (@(posedge clk)
      !rst_n |=> so_oe_n)
      else $error("Serial output driven in reset");

   // A write addressed to channel 4 lands in its mode register
   a_mode_write: assert property (@(posedge clk) disable iff (!rst_n)
      cfg_valid && (cfg.ch == 3'h4) |=> mode_q[4] == $past(cfg.mode))
      else $error("Channel 4 mode write lost");

   // ON command drives the channel unless a clamp holds it off
   a_on_mode_on: assert property (@(posedge clk) disable iff (!rst_n)
      (mode_q[0] == ECS_MODE_ON) && !clp_s_q[0] && !locked_q[0]
      |=> out_en[0])
      else $error("Channel 0 not on in ON mode");

   // Input mode tracks the synchronised pin one edge later
   a_input_follow: assert property (@(posedge clk) disable iff (!rst_n)
      (mode_q[1] == ECS_MODE_INPUT) && !clp_s_q[1] && !locked_q[1]
      |=> out_en[1] == $past(pin_s_q[sel_q[1]]))
      else $error("Channel 1 not following pin");

   // Channel 6 set to the third pin follows that pin only
   a_input_sel: assert property (@(posedge clk) disable iff (!rst_n)
      (mode_q[6] == ECS_MODE_INPUT) && (sel_q[6] == 2'h2)
      && !clp_s_q[6] && !locked_q[6]
      |=> out_en[6] == $past(pin_s_q[2]))
      else $error("Channel 6 not following its pin");

   // Clear keeps the channel off
   a_clear_off: assert property (@(posedge clk) disable iff (!rst_n)
      (mode_q[2] == ECS_MODE_CLEAR) |=> !out_en[2])
      else $error("Cleared channel driven on");

   // OFF keeps the channel off whatever the pins do
   a_off_mode: assert property (@(posedge clk) disable iff (!rst_n)
      (mode_q[4] == ECS_MODE_OFF) |=> !out_en[4])
      else $error("Channel 4 on in OFF mode");

   // All channels in Clear enters standby
   a_standby_all: assert property (@(posedge clk) disable iff (!rst_n)
      (&clr_v) |=> standby)
      else $error("Standby not entered");

   // Any channel out of Clear leaves standby
   a_standby_exit: assert property (@(posedge clk) disable iff (!rst_n)
      !(&clr_v) |=> !standby)
      else $error("Standby held with a channel active");

   // Clamp forces the output off and keeps it off after
   a_clamp_block: assert property (@(posedge clk) disable iff (!rst_n)
      clp_s_q[0] |=> !out_en[0] ##1 !out_en[0])
      else $error("Turn-on during clamp");

   // Clamp ending with enable still high must not turn on
   a_lock_hold: assert property (@(posedge clk) disable iff (!rst_n)
      $fell(clp_s_q[0]) && en_d[0] |=> !out_en[0])
      else $error("Turn-on without new command after clamp");

   // Checked against the pin, not stage one, so nothing here reads
   // the metastable flop
   a_pin_sync: assert property (@(posedge clk) disable iff (!rst_n)
      $rose(pin_s_q[0]) |-> $past(direct_ctrl_pin[0], 2))
      else $error("Pin sync order broken");

   // Three idle select samples release the serial output
   a_so_tristate: assert property (@(posedge clk) disable iff (!rst_n)
      spi_cs_n [*3] |=> so_oe_n)
      else $error("Serial output driven while idle");

endmodule

// ### verif/ecs_host.sv
// Host and direct pin driver model for the switch control bench
`timescale 1ns/10ps
module ecs_host
   import ecs_pkg::*;
(
   // Clock
   input  wire logic          clk,
   // Channel programming
   output logic               cfg_valid,
   output ecs_cfg_s           cfg,
   // Pins, clamp status, chip select
   output logic [NUM_PIN-1:0] direct_ctrl_pin,
   output logic [NUM_CH-1:0]  clamp_active,
   output logic               spi_cs_n
);
   // ------------------------------------------------
   // Idle levels: pins pulled low, bus deselected
   // ------------------------------------------------
   initial begin
      cfg_valid       = 1'b0;
      cfg             = '0;
      direct_ctrl_pin = 4'h0;
      clamp_active    = 8'h00;
      spi_cs_n        = 1'b1;
   end
   // One channel per cycle, strobe held across a burst
   task automatic write(input logic [2:0] ch, input logic [1:0] md,
                        input logic [1:0] sel);
      cfg_valid = 1'b1;
      cfg       = '{ch: ch, mode: md, pin_sel: sel};
      @(negedge clk);
   endtask
   // Drop the strobe only after the last write
   task automatic idle();
      cfg_valid = 1'b0;
      @(negedge clk);
   endtask
   // Pin, clamp and select levels change off the sampling edge
   task automatic drive(input logic [3:0] p, input logic [7:0] c,
                        input logic cs);
      direct_ctrl_pin = p;
      clamp_active    = c;
      spi_cs_n        = cs;
   endtask
endmodule

// ### verif/tb.sv
// Self-checking bench for the eight-channel switch control
`timescale 1ns/10ps
module tb;
   import ecs_pkg::*;
   logic         clk = 1'b0;
   logic         rst_n = 1'b0;
   logic         cfg_valid;
   ecs_cfg_s     cfg;
   logic [3:0]   pins;
   logic [7:0]   clamp;
   logic         cs_n;
   logic [7:0]   out_en;
   logic         standby;
   logic         so_oe_n;
   int           fails = 0;
   int           samples_checked = 0;
   // 100 ns clock
   always #50 clk = ~clk;
   ecs_host host (.clk(clk), .cfg_valid(cfg_valid), .cfg(cfg),
      .direct_ctrl_pin(pins), .clamp_active(clamp), .spi_cs_n(cs_n));
   ecs_switch_ctrl uut (.clk(clk), .rst_n(rst_n), .cfg_valid(cfg_valid),
      .cfg(cfg), .direct_ctrl_pin(pins), .clamp_active(clamp),
      .spi_cs_n(cs_n), .out_en(out_en), .standby(standby),
      .so_oe_n(so_oe_n));
   // Compare and count
   task automatic chk(input logic [7:0] exp, input logic [7:0] got);
      samples_checked++;
      if (got !== exp) begin
         fails++;
         $display("unexpected t=%0t exp=%h got=%h", $time, exp, got);
      end
   endtask
   task automatic wt(input int n);
      repeat (n) @(negedge clk);
   endtask
   task automatic end_sim();
      $display("checks %0d mismatches %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   // Program all eight channels back to back
   task automatic all(input logic [1:0] md);
      for (int i = 0; i < NUM_CH; i++) host.write(3'(i), md, 2'(i % 4));
      host.idle();
      wt(2);
   endtask
   // Host timing in clock cycles of 100 ns
   localparam int RST_LOW_CYC   = 500;    // Reset low 50 us
   localparam int RST_WAKE_CYC  = 2000;   // Reset wake-up 200 us
   // Standby wake-up is up to 200 ms, two million cycles; this model
   // wakes at once, so a short wait stands in for it
   localparam int STBY_WAKE_CYC = 20;
   // Watchdog, tests need about 4600 cycles
   localparam int WDOG_CYC      = 10000;
   initial begin
      wt(WDOG_CYC);
      fails++;
      end_sim();
   end
   // ------------------------------------------------
   // Test sequence
   // ------------------------------------------------
   initial begin
      wt(20);
      chk(8'h00, out_en);
      chk(8'h01, {7'h0, standby});
      chk(8'h01, {7'h0, so_oe_n});
      rst_n = 1'b1;
      wt(RST_WAKE_CYC);
      chk(8'h00, {7'h0, standby});
      all(ECS_MODE_CLEAR);
      chk(8'h01, {7'h0, standby});
      chk(8'h00, out_en);
      all(ECS_MODE_OFF);
      chk(8'h00, {7'h0, standby});
      wt(STBY_WAKE_CYC);
      all(ECS_MODE_ON);
      chk(8'hff, out_en);
      $display("test modes done");
      all(ECS_MODE_INPUT);
      host.drive(4'h5, 8'h00, 1'b1);
      wt(5);
      chk(8'h55, out_en);
      host.drive(4'ha, 8'h00, 1'b1);
      wt(1);
      chk(8'h55, out_en);
      wt(4);
      chk(8'haa, out_en);
      $display("test pins done");
      host.write(3'h0, ECS_MODE_ON, 2'h0);
      host.idle();
      wt(2);
      chk(8'hab, out_en);
      host.drive(4'ha, 8'h01, 1'b1);
      wt(5);
      chk(8'haa, out_en);
      host.drive(4'ha, 8'h00, 1'b1);
      wt(5);
      chk(8'haa, out_en);
      host.write(3'h0, ECS_MODE_OFF, 2'h0);
      host.idle();
      wt(2);
      host.write(3'h0, ECS_MODE_ON, 2'h0);
      host.idle();
      wt(2);
      chk(8'hab, out_en);
      host.write(3'h0, ECS_MODE_CLEAR, 2'h0);
      host.idle();
      wt(2);
      chk(8'haa, out_en);
      $display("test clamp done");
      host.drive(4'ha, 8'h00, 1'b0);
      wt(4);
      chk(8'h00, {7'h0, so_oe_n});
      rst_n = 1'b0;
      wt(2);
      chk(8'h00, out_en);
      chk(8'h01, {7'h0, so_oe_n});
      chk(8'h01, {7'h0, standby});
      wt(RST_LOW_CYC - 2);
      rst_n = 1'b1;
      wt(RST_WAKE_CYC);
      chk(8'h00, out_en);
      chk(8'h00, {7'h0, standby});
      chk(8'h00, {7'h0, so_oe_n});
      $display("test reset done");
      end_sim();
   end
endmodule
